//--- uled_top.sv
// status indicator controller with apb register access
//
// Summary of operation
// - bootloader on usb: green blinks slowly once connected to the host
// - bootloader: slow blink until drivers confirmed, then double blink
// - usb suspend turns green fully off in either mode
// - app mode: slow blink after connect, steady on once drivers confirmed
// - bootloader: red lit with no stored application, dark otherwise
// - shipped without application, red is lit at first power-up
// - no stored application at power-up means bootloader mode
// - red line driven high while red lit, else left pulled low
// - bootloader: yellow steady on, brief flicker per host command
// - bootloader: yellow flickers continuously while programming is in progress
// - yellow line driven high while yellow lit, else left pulled low
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
module uled_top
  import uled_pkg::*;
#(
  parameter int SLOW_HALF = SLOW_HALF_CYC,
  parameter int DBL_STEP  = DBL_STEP_CYC,
  parameter int FLICK     = FLICK_CYC
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // status from usb engine and flash logic
  input  wire logic        usbConnected,
  input  wire logic        usbSuspend,
  input  wire logic        driversConfirmed,
  input  wire logic        hostCommand,
  input  wire logic        programBusy,
  input  wire logic        appPresent,
  // indicators
  output logic             greenLed,
  input  wire logic        redIndicatorLineIn,
  output logic             redIndicatorLineOut,
  output logic             redIndicatorLineOe,
  input  wire logic        yellowIndicatorLineIn,
  output logic             yellowIndicatorLineOut,
  output logic             yellowIndicatorLineOe
);

  // refuse periods the counters cannot serve
  if (SLOW_HALF < 1 || DBL_STEP < 1 || FLICK < 2) begin : g_chk
    $error("uled_top: pattern periods too short");
  end

  localparam int FW = $clog2(FLICK + 1);

  uled_state_t   state_r;
  logic          bootMode_r;
  logic          drvOk_r;
  logic [31:0]   ctrl_r;
  logic [FW-1:0] flickLeft_r;
  uled_led_t     led_r;
  uled_led_t     led_nxt;
  logic [31:0]   prdata_r;
  logic          pready_r;
  logic          pslverr_r;
  logic [2:0]    redSync_r;
  logic [2:0]    yelSync_r;
  logic          redIn_r;
  logic          yelIn_r;
  logic          slowBlink;
  logic          doubleBlink;
  logic          flickWave;

  // blink waveforms
  uled_pattern_gen #(
    .SLOW_HALF (SLOW_HALF),
    .DBL_STEP  (DBL_STEP),
    .FLICK     (FLICK)
  ) u_pattern (
    .mclk        (mclk),
    .rstn        (rstn),
    .slowBlink   (slowBlink),
    .doubleBlink (doubleBlink),
    .flickWave   (flickWave)
  );

  // start-up mode capture after reset release
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r    <= ULED_ST_RESET;
      bootMode_r <= 1'b1;
    end else begin
      case (state_r)
        ULED_ST_RESET:   state_r <= ULED_ST_CAPTURE;
        ULED_ST_CAPTURE: begin
          bootMode_r <= ~appPresent;
          state_r    <= ULED_ST_RUN;
        end
        ULED_ST_RUN:     state_r <= ULED_ST_RUN;
        default:         state_r <= ULED_ST_RESET;
      endcase
    end
  end

  // driver confirmation flag, cleared on disconnect, set wins
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      drvOk_r <= 1'b0;
    end else if (driversConfirmed) begin
      drvOk_r <= 1'b1;
    end else if (!usbConnected) begin
      drvOk_r <= 1'b0;
    end
  end

  // brief dark pulse after each host command
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      flickLeft_r <= '0;
    end else if (hostCommand) begin
      flickLeft_r <= FW'(FLICK);
    end else if (flickLeft_r != '0) begin
      flickLeft_r <= flickLeft_r - 1'b1;
    end
  end

  // green selection
  wire greenActive = usbConnected & ~usbSuspend;
  wire greenBoot   = drvOk_r ? doubleBlink : slowBlink;
  wire greenApp    = drvOk_r ? 1'b1 : slowBlink;
  wire greenSel    = greenActive & (bootMode_r ? greenBoot : greenApp);

  // red selection
  wire redBoot = ~appPresent;
  wire redSel  = bootMode_r ? redBoot : ctrl_r[CTRL_APP_RED];

  // yellow selection
  wire yelCmd  = (flickLeft_r == '0);
  wire yelBoot = programBusy ? flickWave : yelCmd;
  wire yelSel  = bootMode_r ? yelBoot : ctrl_r[CTRL_APP_YELLOW];

  always_comb begin
    led_nxt        = '0;
    led_nxt.green  = greenSel;
    led_nxt.red    = redSel;
    led_nxt.yellow = yelSel;
  end

  // indicator and line flops
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      led_r <= '0;
    end else begin
      led_r <= led_nxt;
    end
  end

  // indicator line pins: drive high when lit, release otherwise
  assign greenLed               = led_r.green;
  assign redIndicatorLineOut    = led_r.red;
  assign redIndicatorLineOe     = led_r.red;
  assign yellowIndicatorLineOut = led_r.yellow;
  assign yellowIndicatorLineOe  = led_r.yellow;

  // pin level readback, three-stage with agreement
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      redSync_r <= '0;
      yelSync_r <= '0;
      redIn_r   <= 1'b0;
      yelIn_r   <= 1'b0;
    end else begin
      redSync_r <= {redSync_r[1:0], redIndicatorLineIn};
      yelSync_r <= {yelSync_r[1:0], yellowIndicatorLineIn};
      if (redSync_r[1] == redSync_r[2]) redIn_r <= redSync_r[2];
      if (yelSync_r[1] == yelSync_r[2]) yelIn_r <= yelSync_r[2];
    end
  end

  // apb decode
  wire apbAccess = psel & penable & ~pready_r;
  wire hitCtrl   = (paddr == ADDR_CTRL);
  wire hitStat   = (paddr == ADDR_STAT);
  wire mapped    = hitCtrl | hitStat;
  wire doWrite   = psel & penable & pready_r & pwrite & hitCtrl;

  // status word
  logic [31:0] statWord;
  always_comb begin
    statWord              = '0;
    statWord[STAT_BOOT]   = bootMode_r;
    statWord[STAT_DRV_OK] = drvOk_r;
    statWord[STAT_GREEN]  = led_r.green;
    statWord[STAT_RED]    = led_r.red;
    statWord[STAT_YELLOW] = led_r.yellow;
    statWord[STAT_RED_IN] = redIn_r;
    statWord[STAT_YEL_IN] = yelIn_r;
  end

  wire [31:0] readWord = hitCtrl ? ctrl_r : (hitStat ? statWord : '0);

  // apb one-wait-state answer
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else begin
      pready_r  <= apbAccess;
      pslverr_r <= apbAccess & ~mapped;
      if (apbAccess && !pwrite) prdata_r <= readWord;
    end
  end

  // control register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= CTRL_RESET;
    end else if (doWrite) begin
      ctrl_r <= pwdata & CTRL_MASK;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // suspend or no usb keeps green dark
  property p_green_off;
    @(posedge mclk) disable iff (!rstn)
      (!usbConnected || usbSuspend) |=> !greenLed;
  endproperty
  a_green_off: assert property (p_green_off)
    else $error("green lit during suspend or detach");

  // bootloader without confirmation follows slow blink
  property p_boot_slow;
    @(posedge mclk) disable iff (!rstn)
      (bootMode_r && greenActive && !drvOk_r) |=> greenLed == $past(slowBlink);
  endproperty
  a_boot_slow: assert property (p_boot_slow)
    else $error("boot green not slow blinking");

  // bootloader after confirmation follows double blink
  property p_boot_dbl;
    @(posedge mclk) disable iff (!rstn)
      (bootMode_r && greenActive && drvOk_r) |=>
        greenLed == $past(doubleBlink);
  endproperty
  a_boot_dbl: assert property (p_boot_dbl)
    else $error("boot green not double blinking");

  // app mode after confirmation is steady on
  property p_app_steady;
    @(posedge mclk) disable iff (!rstn)
      (!bootMode_r && greenActive && drvOk_r) |=> greenLed;
  endproperty
  a_app_steady: assert property (p_app_steady)
    else $error("app green not steady after confirmation");

  // red in bootloader mirrors missing application
  property p_red_boot;
    @(posedge mclk) disable iff (!rstn)
      bootMode_r |=> redIndicatorLineOut == !$past(appPresent);
  endproperty
  a_red_boot: assert property (p_red_boot)
    else $error("red does not reflect application presence");

  // capture picks bootloader exactly when no application is stored
  property p_boot_capture;
    @(posedge mclk) disable iff (!rstn)
      (state_r == ULED_ST_CAPTURE) |=> bootMode_r == !$past(appPresent);
  endproperty
  a_boot_capture: assert property (p_boot_capture)
    else $error("no application but bootloader not entered");

  // app mode: red line follows its control bit, driven only while lit
  property p_red_line;
    @(posedge mclk) disable iff (!rstn)
      !bootMode_r |=> redIndicatorLineOut == $past(ctrl_r[CTRL_APP_RED]) &&
        redIndicatorLineOe == redIndicatorLineOut;
  endproperty
  a_red_line: assert property (p_red_line)
    else $error("red line drive mismatch");

  // host command makes yellow dark shortly, then lit again
  property p_yel_flicker;
    @(posedge mclk) disable iff (!rstn)
      (bootMode_r && !programBusy && hostCommand) ##1
        (bootMode_r && !programBusy && !hostCommand) |=>
        !yellowIndicatorLineOut;
  endproperty
  a_yel_flicker: assert property (p_yel_flicker)
    else $error("no yellow flicker after host command");

  // programming follows the flicker wave
  property p_yel_prog;
    @(posedge mclk) disable iff (!rstn)
      (bootMode_r && programBusy) |=>
        yellowIndicatorLineOut == $past(flickWave);
  endproperty
  a_yel_prog: assert property (p_yel_prog)
    else $error("yellow not flickering while programming");

  // bootloader yellow with no pending flicker is lit and driven high
  property p_yel_line;
    @(posedge mclk) disable iff (!rstn)
      (bootMode_r && !programBusy && flickLeft_r == '0) |=>
        yellowIndicatorLineOut && yellowIndicatorLineOe;
  endproperty
  a_yel_line: assert property (p_yel_line)
    else $error("yellow line drive mismatch");

  // flicker pulse length follows the parameter
  property p_flick_len;
    @(posedge mclk) disable iff (!rstn)
      hostCommand |=> flickLeft_r == FW'(FLICK);
  endproperty
  a_flick_len: assert property (p_flick_len)
    else $error("flicker length not loaded");

endmodule

//--- uled_pkg.sv
// shared constants and types for the status indicator block
package uled_pkg;

  // clock rate and pattern durations in their own units
  localparam int CLK_KHZ       = 50000;
  localparam int SLOW_HALF_MS  = 500;
  localparam int DBL_STEP_MS   = 100;
  localparam int FLICK_MS      = 40;

  // derived cycle counts (longest times, rounded down, at least one)
  localparam int SLOW_HALF_CYC = (SLOW_HALF_MS * CLK_KHZ < 1) ? 1 :
                                 SLOW_HALF_MS * CLK_KHZ;
  localparam int DBL_STEP_CYC  = (DBL_STEP_MS * CLK_KHZ < 1) ? 1 :
                                 DBL_STEP_MS * CLK_KHZ;
  localparam int FLICK_CYC     = (FLICK_MS * CLK_KHZ < 1) ? 1 :
                                 FLICK_MS * CLK_KHZ;

  // double blink: on, off, on, then dark for the rest of the frame
  localparam logic [7:0] DBL_PATTERN = 8'h05;
  localparam int         DBL_STEPS   = 8;

  // register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;

  // control register fields
  localparam int CTRL_APP_RED    = 0;
  localparam int CTRL_APP_YELLOW = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK  = 32'h0000_0003;

  // status register fields
  localparam int STAT_BOOT    = 0;
  localparam int STAT_DRV_OK  = 1;
  localparam int STAT_GREEN   = 2;
  localparam int STAT_RED     = 3;
  localparam int STAT_YELLOW  = 4;
  localparam int STAT_RED_IN  = 5;
  localparam int STAT_YEL_IN  = 6;

  // indicator levels travel together
  typedef struct packed {
    logic green;
    logic red;
    logic yellow;
  } uled_led_t;

  // phase of the start-up mode capture
  typedef enum logic [1:0] {
    ULED_ST_RESET,
    ULED_ST_CAPTURE,
    ULED_ST_RUN
  } uled_state_t;

endpackage

//--- uled_pattern_gen.sv
// free-running blink waveforms for the indicators
`timescale 1ns/1ps
module uled_pattern_gen
  import uled_pkg::*;
#(
  parameter int SLOW_HALF = SLOW_HALF_CYC,
  parameter int DBL_STEP  = DBL_STEP_CYC,
  parameter int FLICK     = FLICK_CYC
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rstn,
  // waveforms
  output logic      slowBlink,
  output logic      doubleBlink,
  output logic      flickWave
);

  // counter widths follow the periods
  localparam int SW = $clog2(SLOW_HALF + 1);
  localparam int DW = $clog2(DBL_STEP + 1);
  localparam int FW = $clog2(FLICK + 1);

  logic [SW-1:0] slowCnt_r;
  logic [DW-1:0] dblCnt_r;
  logic [FW-1:0] flickCnt_r;
  logic [2:0]    dblStep_r;
  logic          slow_r;
  logic          flick_r;

  // terminal counts
  wire slowEnd  = (slowCnt_r == SW'(SLOW_HALF - 1));
  wire dblEnd   = (dblCnt_r == DW'(DBL_STEP - 1));
  wire flickEnd = (flickCnt_r == FW'(FLICK - 1));

  // slow blink and flicker square waves
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      slowCnt_r  <= '0;
      flickCnt_r <= '0;
      slow_r     <= 1'b1;
      flick_r    <= 1'b1;
    end else begin
      slowCnt_r  <= slowEnd ? '0 : slowCnt_r + 1'b1;
      flickCnt_r <= flickEnd ? '0 : flickCnt_r + 1'b1;
      if (slowEnd) slow_r <= ~slow_r;
      if (flickEnd) flick_r <= ~flick_r;
    end
  end

  // double blink step sequencer
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dblCnt_r  <= '0;
      dblStep_r <= '0;
    end else begin
      dblCnt_r <= dblEnd ? '0 : dblCnt_r + 1'b1;
      if (dblEnd) dblStep_r <= dblStep_r + 1'b1;
    end
  end

  assign slowBlink   = slow_r;
  assign doubleBlink = DBL_PATTERN[dblStep_r];
  assign flickWave   = flick_r;

endmodule

//--- uled_host_model.sv
// host side model: usb attach, suspend, driver confirm and polling
`timescale 1ns/1ps
module uled_host_model #(
  parameter int POLL = 40
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rstn,
  // scenario control
  input  wire logic attach,
  input  wire logic sleep,
  input  wire logic confirm,
  input  wire logic pollEn,
  // usb status toward the device
  output logic      usbConnected,
  output logic      usbSuspend,
  output logic      driversConfirmed,
  output logic      hostCommand
);
  logic confirm_r;
  int   pollCnt_r;

  // link levels follow the cable and host sleep
  assign usbConnected = attach;
  assign usbSuspend   = attach & sleep;

  // one confirm message per request edge, only while attached
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      confirm_r        <= 1'b0;
      driversConfirmed <= 1'b0;
    end else begin
      confirm_r        <= confirm;
      driversConfirmed <= confirm & ~confirm_r & attach;
    end
  end

  // periodic state query while the tool is open
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pollCnt_r   <= 0;
      hostCommand <= 1'b0;
    end else begin
      pollCnt_r   <= (!pollEn || pollCnt_r == POLL - 1) ? 0 : pollCnt_r + 1;
      hostCommand <= pollEn && pollCnt_r == POLL - 1;
    end
  end
endmodule

//--- tb_top.sv
// self-checking bench for the status indicator block
`timescale 1ns/1ps
module tb_top;
  import uled_pkg::*;
  localparam int SH   = 8;
  localparam int DS   = 4;
  localparam int FL   = 3;
  localparam int POLL = 40;
  logic        mclk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        usbConnected, usbSuspend, driversConfirmed, hostCommand;
  logic        programBusy, appPresent, greenLed;
  logic        redIn, redOut, redOe, yelIn, yelOut, yelOe;
  logic        attach, sleep, confirm, pollEn;
  int          err_count, cmp_count, n;

  // pins are pulled low when not driven
  assign redIn = redOe ? redOut : 1'b0;
  assign yelIn = yelOe ? yelOut : 1'b0;

  uled_top #(.SLOW_HALF(SH), .DBL_STEP(DS), .FLICK(FL)) i_uled_top (
    .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .usbConnected(usbConnected),
    .usbSuspend(usbSuspend), .driversConfirmed(driversConfirmed),
    .hostCommand(hostCommand), .programBusy(programBusy),
    .appPresent(appPresent), .greenLed(greenLed),
    .redIndicatorLineIn(redIn), .redIndicatorLineOut(redOut),
    .redIndicatorLineOe(redOe), .yellowIndicatorLineIn(yelIn),
    .yellowIndicatorLineOut(yelOut), .yellowIndicatorLineOe(yelOe));

  uled_host_model #(.POLL(POLL)) i_uled_host_model (
    .mclk(mclk), .rstn(rstn), .attach(attach), .sleep(sleep),
    .confirm(confirm), .pollEn(pollEn), .usbConnected(usbConnected),
    .usbSuspend(usbSuspend), .driversConfirmed(driversConfirmed),
    .hostCommand(hostCommand));

  // 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic wt(input int c);
    repeat (c) @(posedge mclk);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, error checked in full, read data checked under a mask
  task automatic acc(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, input logic [31:0] exp,
                     input logic [31:0] msk, input logic eerr);
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    chk({31'h0, pslverr}, {31'h0, eerr});
    if (!wr)
      chk(prdata & msk, exp & msk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // lit cycles of green or yellow over a window
  task automatic count(input bit yel, input int len);
    n = 0;
    repeat (len) begin
      @(posedge mclk);
      n += yel ? int'(yelOut === 1'b1) : int'(greenLed === 1'b1);
    end
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    #100000;
    err_count++;
    final_report();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {attach, sleep, confirm, pollEn, programBusy, appPresent} = '0;
    err_count = 0;
    cmp_count = 0;
    rstn = 1'b0;
    wt(20);
    rstn <= 1'b1;
    wt(4);
    acc(0, ADDR_STAT, 0, 32'h79, 32'hffff_ffff, 0);
    chk(32'({redOut, redOe, redIn}), 32'h7);
    chk(32'({yelOut, yelOe, yelIn}), 32'h7);
    acc(0, ADDR_CTRL, 0, CTRL_RESET, 32'hffff_ffff, 0);
    acc(0, 12'h008, 0, 32'h0, 32'hffff_ffff, 1);
    acc(1, 12'h008, 32'h3, 0, 0, 1);
    acc(1, ADDR_STAT, 32'hffff_ffff, 0, 0, 0);
    acc(0, ADDR_STAT, 0, 32'h79, 32'hffff_ffff, 0);
    done("boot idle");
    attach <= 1'b1;
    wt(4);
    count(0, 4 * SH);
    chk(32'(n), 32'(2 * SH));
    confirm <= 1'b1;
    wt(4);
    count(0, DBL_STEPS * DS);
    chk(32'(n), 32'(2 * DS));
    acc(0, ADDR_STAT, 0, 32'h7b, 32'h7b, 0);
    sleep <= 1'b1;
    wt(3);
    count(0, 4 * SH);
    chk(32'(n), 32'h0);
    sleep   <= 1'b0;
    confirm <= 1'b0;
    done("boot green");
    pollEn <= 1'b1;
    wt(POLL + 4);
    count(1, POLL);
    chk(32'(n), 32'(POLL - FL));
    pollEn <= 1'b0;
    wt(10);
    programBusy <= 1'b1;
    wt(3);
    count(1, 4 * FL);
    chk(32'(n), 32'(2 * FL));
    programBusy <= 1'b0;
    attach      <= 1'b0;
    wt(10);
    acc(0, ADDR_STAT, 0, 32'h79, 32'h7f, 0);
    done("boot yellow");
    appPresent <= 1'b1;
    rstn       <= 1'b0;
    wt(20);
    rstn <= 1'b1;
    wt(8);
    acc(0, ADDR_STAT, 0, 32'h0, 32'h7f, 0);
    acc(1, ADDR_CTRL, 32'h3, 0, 0, 0);
    wt(2);
    chk(32'({redOut, redOe, yelOut, yelOe}), 32'hf);
    acc(0, ADDR_CTRL, 0, 32'h3, 32'hffff_ffff, 0);
    attach <= 1'b1;
    wt(4);
    count(0, 4 * SH);
    chk(32'(n), 32'(2 * SH));
    confirm <= 1'b1;
    wt(4);
    count(0, 4 * SH);
    chk(32'(n), 32'(4 * SH));
    acc(1, ADDR_CTRL, 32'h0, 0, 0, 0);
    wt(2);
    chk(32'({redOut, redOe, yelOut, yelOe}), 32'h0);
    done("app mode");
    final_report();
  end
endmodule
